/* File: drive_motion_limits_regs.svh */
/*
 Register indices, reset values, ranges and timing figures of the
 motion-limit block. Assumes word-addressed APB: byte address is
 four times the index.
*/
`ifndef DRIVE_MOTION_LIMITS_REGS_SVH
`define DRIVE_MOTION_LIMITS_REGS_SVH
`define DML_IDX_DRAG_THR 8'h2e
`define DML_IDX_READJUST 8'h2f
`define DML_IDX_CORR_LIM 8'h30
`define DML_IDX_JOG_STEP 8'h31
`define DML_IDX_POS_SPD 8'h35
`define DML_IDX_MAN_SPD 8'h38
`define DML_IDX_ABORT_PCT 8'h39
`define DML_IDX_ACCEL 8'h3a
`define DML_IDX_DECEL 8'h3b
`define DML_IDX_START_TQ 8'h3f
`define DML_IDX_RUN_TQ 8'h40
`define DML_IDX_END_TQ 8'h41
`define DML_IDX_HOLD_TQ 8'h42
`define DML_IDX_END_MS 8'h48
`define DML_IDX_STATUS 8'h50
`define DML_IDX_CLEAR 8'h51
`define DML_IDX_ENABLE 8'h52
`define DML_IDX_STATE 8'h53
`define DML_RST_DRAG_THR 16'h0000
`define DML_RST_READJUST 16'h0000
`define DML_RST_CORR_LIM 16'h0004
`define DML_RST_JOG_STEP 16'h0001
`define DML_RST_ABORT_PCT 16'h001e
`define DML_RST_END_MS 16'h00c8
`define DML_READJUST_MAX 16'h0001
`define DML_CORR_MAX 16'h000a
`define DML_JOG_MIN 16'h0001
`define DML_JOG_MAX 16'h0064
`define DML_PCT_MIN 16'h001e
`define DML_PCT_MAX 16'h005a
`define DML_END_MS_MAX 16'h03e8
`define DML_PCT_DIV 16'h0064
`define DML_MS_PER_S 17'h003e8
`define DML_MS_NS 1000000
`define DML_CLK_NS 100
`define DML_EV_DRAG 0
`define DML_EV_ABORT 1
`define DML_EV_DONE 2
`define DML_EV_REFUSED 3
`define DML_NUM_EV 4
`endif

/* File: dml_pkg.sv */
/*
 Types shared by the motion-limit block: APB request carrier, motion
 phases and the motion status bundle. Assumes nothing outside.
*/
package dml_pkg;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } dml_apb_req_s;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_START,
      ST_RUN,
      ST_STOP,
      ST_END_HOLD
   } dml_phase_e;

   typedef struct packed {
      logic [15:0] speed;
      logic [15:0] torque_limit;
      logic [15:0] abort_speed;
      logic drag_error;
      logic current_limiting;
      logic readjust_active;
      logic moving;
   } dml_motion_s;
endpackage : dml_pkg

/* File: drive_motion_limits.sv */
/*
 Motion-limit and supervision logic of a spindle positioning drive:
 parameter registers on APB, speed ramp, torque phase selection, drag
 error supervision, jog steps and an interrupt. Assumes target and
 actual positions in hundredths of a millimetre, synchronous to clk,
 and a measured torque in cNm from the current loop.
*/
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`include "drive_motion_limits_regs.svh"

// Notes on behaviour
// - Drag flag when following error exceeds threshold.
// - Readjust accepts 0/1, corrects at standstill.
// - Drag speed correction capped, standstill-only change.
// - Each jog press at standstill moves 1..100 steps; the code repeats the burst on every clock that jog_press stays high.
// - Positioning runs capped at positioning ceiling.
// - Manual runs capped at manual ceiling.
// - Abort threshold is 30..90 percent target.
// - Ramp with acceleration and deceleration rates.
// - Start torque limit, then running limit.
// - End-of-run hold limit, then standstill hold.
// - Current limited; torque never above active limit.
// - End hold lasts given milliseconds, default 200.
module dml_drive_motion_limits
   import dml_pkg::*;
#(
   parameter logic [15:0] POS_SPD_RST = 16'h0bb8,
   parameter logic [15:0] MAN_SPD_RST = 16'h03e8,
   parameter logic [15:0] ACCEL_RST = 16'h2710,
   parameter logic [15:0] DECEL_RST = 16'h2710,
   parameter logic [15:0] TQ_RST = 16'h0064,
   parameter int MS_CYCLES = `DML_MS_NS / `DML_CLK_NS
) (
   input wire logic clk,
   input wire logic reset,
   input wire dml_apb_req_s apb_req,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic run_req,
   input wire logic manual_req,
   input wire logic jog_press,
   input wire logic signed [31:0] target_pos,
   input wire logic signed [31:0] actual_pos,
   input wire logic [15:0] motor_torque,
   output dml_motion_s motion,
   output logic jog_step_valid,
   output logic [15:0] jog_steps,
   output logic irq
);
   localparam int NP = 14;
   localparam int MSW = $clog2(MS_CYCLES + 1);

   // A zero-length tick would stall every ramp and the hold window.
   if (MS_CYCLES < 1) begin : g_ms_check
      $error("MS_CYCLES must be at least one");
   end

   function automatic logic [3:0] par_index(input logic [7:0] idx);
      case (idx)
         `DML_IDX_DRAG_THR: par_index = 4'h0;
         `DML_IDX_READJUST: par_index = 4'h1;
         `DML_IDX_CORR_LIM: par_index = 4'h2;
         `DML_IDX_JOG_STEP: par_index = 4'h3;
         `DML_IDX_POS_SPD: par_index = 4'h4;
         `DML_IDX_MAN_SPD: par_index = 4'h5;
         `DML_IDX_ABORT_PCT: par_index = 4'h6;
         `DML_IDX_ACCEL: par_index = 4'h7;
         `DML_IDX_DECEL: par_index = 4'h8;
         `DML_IDX_START_TQ: par_index = 4'h9;
         `DML_IDX_RUN_TQ: par_index = 4'ha;
         `DML_IDX_END_TQ: par_index = 4'hb;
         `DML_IDX_HOLD_TQ: par_index = 4'hc;
         `DML_IDX_END_MS: par_index = 4'hd;
         default: par_index = 4'hf;
      endcase
   endfunction : par_index

   function automatic logic [15:0] par_reset(input int i);
      case (i)
         0: par_reset = `DML_RST_DRAG_THR;
         1: par_reset = `DML_RST_READJUST;
         2: par_reset = `DML_RST_CORR_LIM;
         3: par_reset = `DML_RST_JOG_STEP;
         4: par_reset = POS_SPD_RST;
         5: par_reset = MAN_SPD_RST;
         6: par_reset = `DML_RST_ABORT_PCT;
         7: par_reset = ACCEL_RST;
         8: par_reset = DECEL_RST;
         13: par_reset = `DML_RST_END_MS;
         default: par_reset = TQ_RST;
      endcase
   endfunction : par_reset

   // Ramp step in rpm per millisecond tick from the carried fraction.
   function automatic logic [15:0] ramp_quot(input logic [16:0] sum);
      logic [16:0] q;
      q = sum / `DML_MS_PER_S;
      ramp_quot = q[15:0];
   endfunction : ramp_quot

   function automatic logic [16:0] ramp_rem(input logic [16:0] sum);
      ramp_rem = sum % `DML_MS_PER_S;
   endfunction : ramp_rem

   function automatic logic [15:0] min16(input logic [15:0] a,
                                         input logic [15:0] b);
      min16 = (a < b) ? a : b;
   endfunction : min16

   logic [15:0] prm [NP];
   logic [`DML_NUM_EV-1:0] status;
   logic [`DML_NUM_EV-1:0] enable;
   dml_phase_e phase;
   dml_phase_e next_phase;
   logic manual_mode;
   logic [15:0] speed;
   logic [16:0] acc_up;
   logic [16:0] acc_dn;
   logic [MSW-1:0] ms_cnt;
   logic [15:0] hold_ms;
   logic drag_prev;
   logic abort_prev;

   // Bus decode.
   wire [7:0] reg_idx = apb_req.paddr[9:2];
   wire [3:0] pidx = par_index(reg_idx);
   wire is_par = (pidx != 4'hf) && (apb_req.paddr[1:0] == 2'b00)
                 && (apb_req.paddr[11:10] == 2'b00);
   wire is_status = (apb_req.paddr == {2'b00, `DML_IDX_STATUS, 2'b00});
   wire is_clear = (apb_req.paddr == {2'b00, `DML_IDX_CLEAR, 2'b00});
   wire is_enable = (apb_req.paddr == {2'b00, `DML_IDX_ENABLE, 2'b00});
   wire is_state = (apb_req.paddr == {2'b00, `DML_IDX_STATE, 2'b00});
   wire mapped = is_par || is_status || is_clear || is_enable || is_state;
   wire access = apb_req.psel && apb_req.penable;
   wire setup = apb_req.psel && !apb_req.penable;
   wire wr_acc = access && apb_req.pwrite;
   wire [15:0] wval = apb_req.pwdata[15:0];

   // Standstill needs the ramp at zero as well, not only the idle phase.
   wire standstill = (phase == ST_IDLE) && (speed == 16'h0000);

   wire wval_ok = (pidx == 4'h1) ? (wval <= `DML_READJUST_MAX) :
                  (pidx == 4'h2) ? (wval <= `DML_CORR_MAX) :
                  (pidx == 4'h3) ? (wval >= `DML_JOG_MIN &&
                                    wval <= `DML_JOG_MAX) :
                  (pidx == 4'h6) ? (wval >= `DML_PCT_MIN &&
                                    wval <= `DML_PCT_MAX) :
                  (pidx == 4'hd) ? (wval <= `DML_END_MS_MAX) : 1'b1;
   wire locked = (pidx == 4'h2) && !standstill;
   wire par_wr = wr_acc && is_par && wval_ok && !locked;
   wire refused = wr_acc && is_par && (!wval_ok || locked);

   // Every register answers at once, so the bus never waits.
   assign pready = 1'b1;
   assign pslverr = access && (!mapped || (is_clear && !apb_req.pwrite)
                    || (is_status && apb_req.pwrite));

   // Read data is captured in the setup cycle, so it is a flop output.
   wire [31:0] rd_mux = is_par ? {16'h0000, prm[pidx]} :
                        is_status ? {28'h0000000, status} :
                        is_enable ? {28'h0000000, enable} :
                        is_state ? {29'h00000000, phase} : 32'h00000000;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         prdata <= 32'h00000000;
      end else if (setup) begin
         prdata <= rd_mux;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < NP; i++) begin
            prm[i] <= par_reset(i);
         end
      end else if (par_wr) begin
         prm[pidx] <= wval;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         enable <= '0;
      end else if (wr_acc && is_enable) begin
         enable <= apb_req.pwdata[`DML_NUM_EV-1:0];
      end
   end

   // Millisecond tick from the one system clock.
   wire ms_tick = (ms_cnt == MSW'(MS_CYCLES - 1));
   // restart tick at hold.
   // Otherwise the first millisecond of the hold would be a partial one.
   wire hold_start = (phase == ST_STOP) && (next_phase == ST_END_HOLD);
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ms_cnt <= '0;
      end else begin
         ms_cnt <= (ms_tick || hold_start) ? '0 : ms_cnt + 1'b1;
      end
   end

   // following error magnitude against threshold.
   // The difference is taken one bit wider so that it cannot overflow.
   wire signed [32:0] err = 33'(target_pos) - 33'(actual_pos);
   wire [32:0] err_abs = err[32] ? 33'(-err) : 33'(err);
   wire drag_error = err_abs > {17'h00000, prm[0]};
   wire [15:0] err_sat = (err_abs[32:16] != 17'h00000) ? 16'hffff
                         : err_abs[15:0];

   // ceiling depends on the kind of run.
   wire [15:0] ceiling = manual_mode ? prm[5] : prm[4];
   wire active_run = (phase == ST_START) || (phase == ST_RUN);
   wire [15:0] ramp_target = active_run ? ceiling : 16'h0000;

   wire [15:0] torque_limit = (phase == ST_START) ? prm[9] :
                              (phase == ST_RUN || phase == ST_STOP)
                              ? prm[10] :
                              (phase == ST_END_HOLD) ? prm[11] : prm[12];
   // stop accelerating once torque reaches the limit.
   wire at_limit = motor_torque >= torque_limit;

   // ramp steps carry their fraction across ticks.
   wire [16:0] sum_up = acc_up + 17'(prm[7]);
   wire [16:0] sum_dn = acc_dn + 17'(prm[8]);
   wire [15:0] step_up = min16(ramp_quot(sum_up), ramp_target - speed);
   wire [15:0] step_dn = min16(ramp_quot(sum_dn), speed - ramp_target);
   wire go_up = ms_tick && (speed < ramp_target) && !at_limit;
   wire go_dn = ms_tick && (speed > ramp_target);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         speed <= 16'h0000;
         acc_up <= '0;
         acc_dn <= '0;
      end else if (go_up) begin
         speed <= speed + step_up;
         acc_up <= ramp_rem(sum_up);
      end else if (go_dn) begin
         speed <= speed - step_dn;
         acc_dn <= ramp_rem(sum_dn);
      end
   end

   // correction trims the ramp, so the ceiling still holds.
   wire [15:0] corr = (active_run && drag_error) ? min16(err_sat, prm[2])
                      : 16'h0000;
   wire [15:0] speed_out = (speed > corr) ? speed - corr : 16'h0000;

   // abort threshold as a percentage of the target speed.
   // The product is formed at full width before the division truncates.
   wire [31:0] abort_prod = ceiling * prm[6];
   wire [31:0] abort_q = abort_prod / {16'h0000, `DML_PCT_DIV};
   wire [15:0] abort_speed = abort_q[15:0];
   wire abort_low = (phase == ST_RUN) && (speed_out < abort_speed);

   // The kind of run is latched at start, so a late second request waits.
   wire req = manual_mode ? manual_req : run_req;
   wire hold_done = (hold_ms >= prm[13]);

   always_comb begin
      next_phase = phase;
      case (phase)
         ST_IDLE: begin
            if (run_req || manual_req) begin
               next_phase = ST_START;
            end
         end
         ST_START: begin
            if (!req) begin
               next_phase = ST_STOP;
            end else if (speed == ceiling) begin
               next_phase = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!req) begin
               next_phase = ST_STOP;
            end
         end
         ST_STOP: begin
            if (speed == 16'h0000) begin
               next_phase = ST_END_HOLD;
            end
         end
         ST_END_HOLD: begin
            if (hold_done) begin
               next_phase = ST_IDLE;
            end
         end
         default: next_phase = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         phase <= ST_IDLE;
         manual_mode <= 1'b0;
         hold_ms <= 16'h0000;
      end else begin
         phase <= next_phase;
         if (phase == ST_IDLE && next_phase == ST_START) begin
            manual_mode <= !run_req;
         end
         if (phase != ST_END_HOLD) begin
            hold_ms <= 16'h0000;
         end else if (ms_tick && !hold_done) begin
            hold_ms <= hold_ms + 16'h0001;
         end
      end
   end

   // one step burst per clock that jog_press is high, only at standstill.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         jog_step_valid <= 1'b0;
         jog_steps <= 16'h0000;
      end else begin
         jog_step_valid <= jog_press && standstill;
         if (jog_press && standstill) begin
            jog_steps <= prm[3];
         end
      end
   end

   wire [`DML_NUM_EV-1:0] ev;
   assign ev[`DML_EV_DRAG] = drag_error && !drag_prev;
   assign ev[`DML_EV_ABORT] = abort_low && !abort_prev;
   assign ev[`DML_EV_DONE] = (phase == ST_END_HOLD) && hold_done;
   assign ev[`DML_EV_REFUSED] = refused;
   wire [`DML_NUM_EV-1:0] clr = (wr_acc && is_clear)
                                ? apb_req.pwdata[`DML_NUM_EV-1:0] : '0;

   // A new event beats a clear in the same cycle, so none is lost.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         status <= '0;
         drag_prev <= 1'b0;
         abort_prev <= 1'b0;
      end else begin
         status <= (status & ~clr) | ev;
         drag_prev <= drag_error;
         abort_prev <= abort_low;
      end
   end

   // The interrupt is a level; software clears the cause to drop it.
   assign irq = |(status & enable);

   // readjust only when enabled, at standstill, and off target.
   wire readjust_active = prm[1][0] && standstill && (err_abs != '0);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         motion <= '0;
      end else begin
         motion.speed <= speed_out;
         // active limit goes to the current regulator.
         motion.torque_limit <= torque_limit;
         motion.abort_speed <= abort_speed;
         motion.drag_error <= drag_error;
         motion.current_limiting <= at_limit;
         motion.readjust_active <= readjust_active;
         motion.moving <= !standstill;
      end
   end
endmodule : dml_drive_motion_limits

/* File: dml_drive_motion_limits_properties.sv */
/*
 Port checker of the motion-limit block.
 Assumes binding to dml_drive_motion_limits on one clock and reset.
*/
`timescale 1ns/1ps
module dml_properties
   import dml_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire dml_apb_req_s apb_req,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic run_req,
   input wire logic manual_req,
   input wire logic jog_press,
   input wire logic signed [31:0] target_pos,
   input wire logic signed [31:0] actual_pos,
   input wire logic [15:0] motor_torque,
   input wire dml_motion_s motion,
   input wire logic jog_step_valid,
   input wire logic [15:0] jog_steps,
   input wire logic irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   wire acc = apb_req.psel && apb_req.penable;
   wire [7:0] idx = apb_req.paddr[9:2];
   refused_no_error_a:
      assert property (acc && apb_req.pwrite && apb_req.paddr inside
         {12'h0bc, 12'h0c0, 12'h0c4, 12'h0e4, 12'h120} |-> !pslverr)
      else $error("error response on a ranged parameter write");
   readjust_width_a:
      assert property (acc && !apb_req.pwrite && idx == 8'h2f
         |-> prdata[31:1] == 31'h0)
      else $error("readjust reads wider than one bit");
   jog_cause_a:
      assert property (jog_step_valid |-> $past(jog_press))
      else $error("jog step without a press");
   jog_range_a:
      assert property (jog_step_valid |-> jog_steps inside {[1:100]})
      else $error("jog step count out of range");
   jog_refused_a:
      assert property (jog_step_valid |-> !motion.moving)
      else $error("jog step while moving");
   drag_cause_a:
      assert property (motion.drag_error |-> $past(target_pos) !=
         $past(actual_pos))
      else $error("drag flag without following error");
   readjust_still_a:
      assert property (motion.readjust_active |-> !motion.moving)
      else $error("readjust active while moving");
   torque_cap_a:
      assert property ((motor_torque == 16'hffff) [*3]
         |-> motion.speed <= $past(motion.speed))
      else $error("speed rose at torque limit");
endmodule : dml_properties

bind dml_drive_motion_limits dml_properties i_props (.clk(clk),
   .reset(reset), .apb_req(apb_req), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .run_req(run_req), .manual_req(manual_req),
   .jog_press(jog_press), .target_pos(target_pos),
   .actual_pos(actual_pos), .motor_torque(motor_torque),
   .motion(motion), .jog_step_valid(jog_step_valid),
   .jog_steps(jog_steps), .irq(irq));

/* File: dml_apb_master.sv */
/*
 APB master model standing for the fieldbus side.
 Assumes a slave on the same clock; waits for pready with no bound.
*/
`timescale 1ns/1ps
module dml_apb_master
   import dml_pkg::*;
(
   input wire logic clk,
   output dml_apb_req_s req,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial req = '0;
   // Request held until pready is sampled high, then released.
   task automatic xfer(input logic w, input logic [7:0] idx,
         input logic [31:0] wd, output logic [31:0] rd, output logic err);
      @(posedge clk);
      req <= '{1'b1, 1'b0, w, {2'b00, idx, 2'b00}, wd};
      @(posedge clk);
      req.penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      req.pwdata <= ~wd;
   endtask : xfer
endmodule : dml_apb_master

/* File: drive_motion_limits_tb.sv */
/*
 Self-checking bench of the motion-limit block: parameter table,
 refusals, interrupt, jog, runs and torque phases.
 Assumes the APB master model and the bound port checker.
*/
`timescale 1ns/1ps
`include "drive_motion_limits_regs.svh"
module drive_motion_limits_tb import dml_pkg::*;;
   typedef struct packed {
      logic wr;
      logic [7:0] idx;
      logic [15:0] wd;
      logic [15:0] ex;
   } dml_row_s;
   localparam dml_row_s ROWS [28] = '{
      '{1'b0, 8'h2e, 16'h0, 16'h0}, '{1'b0, 8'h2f, 16'h0, 16'h0},
      '{1'b0, 8'h30, 16'h0, 16'h4}, '{1'b0, 8'h31, 16'h0, 16'h1},
      '{1'b0, 8'h39, 16'h0, 16'h1e}, '{1'b0, 8'h48, 16'h0, 16'hc8},
      '{1'b0, 8'h35, 16'h0, 16'hbb8}, '{1'b0, 8'h38, 16'h0, 16'h3e8},
      '{1'b1, 8'h2f, 16'h2, 16'h0}, '{1'b1, 8'h2f, 16'h1, 16'h1},
      '{1'b1, 8'h30, 16'hb, 16'h4}, '{1'b1, 8'h30, 16'ha, 16'ha},
      '{1'b1, 8'h31, 16'h0, 16'h1}, '{1'b1, 8'h31, 16'h65, 16'h1},
      '{1'b1, 8'h31, 16'h64, 16'h64}, '{1'b1, 8'h39, 16'h1d, 16'h1e},
      '{1'b1, 8'h39, 16'h5b, 16'h1e}, '{1'b1, 8'h39, 16'h5a, 16'h5a},
      '{1'b1, 8'h48, 16'h3e9, 16'hc8}, '{1'b1, 8'h48, 16'h3, 16'h3},
      '{1'b1, 8'h2e, 16'h4, 16'h4}, '{1'b1, 8'h35, 16'h14, 16'h14},
      '{1'b1, 8'h38, 16'ha, 16'ha}, '{1'b1, 8'h3a, 16'h3e8, 16'h3e8},
      '{1'b1, 8'h3b, 16'h7d0, 16'h7d0}, '{1'b1, 8'h3f, 16'h11, 16'h11},
      '{1'b1, 8'h40, 16'h22, 16'h22}, '{1'b1, 8'h41, 16'h33, 16'h33}};
   logic clk = 0;
   logic reset = 1;
   dml_apb_req_s apb_req;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic run_req = 0;
   logic manual_req = 0;
   logic jog_press = 0;
   logic signed [31:0] target_pos = 0;
   logic signed [31:0] actual_pos = 0;
   logic [15:0] motor_torque = 0;
   dml_motion_s motion;
   logic jog_step_valid;
   logic [15:0] jog_steps;
   logic irq;
   logic [31:0] rdv;
   logic erv;
   logic [15:0] s0;
   int wcnt;
   int cycles = 0;
   int n_errors = 0;
   int n_checks = 0;
   always #50 clk = ~clk;
   dml_drive_motion_limits #(.MS_CYCLES(10)) i_dut (.clk(clk),
      .reset(reset), .apb_req(apb_req), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .run_req(run_req), .manual_req(manual_req),
      .jog_press(jog_press), .target_pos(target_pos),
      .actual_pos(actual_pos), .motor_torque(motor_torque),
      .motion(motion), .jog_step_valid(jog_step_valid),
      .jog_steps(jog_steps), .irq(irq));
   dml_apb_master i_master (.clk(clk), .req(apb_req), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   task automatic give_verdict();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : give_verdict
   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
         input string name);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [7:0] idx, input logic [15:0] d);
      i_master.xfer(1'b1, idx, {16'h0, d}, rdv, erv);
   endtask : wr
   task automatic rd(input logic [7:0] idx);
      i_master.xfer(1'b0, idx, 32'h0, rdv, erv);
   endtask : rd
   // A bounded wait: a hang is judged by the range check that follows.
   task automatic wait_for(input bit tq, input logic [15:0] v);
      wcnt = 0;
      while ((tq ? motion.torque_limit : motion.speed) !== v
            && wcnt < 3000) begin
         @(posedge clk);
         wcnt++;
      end
   endtask : wait_for
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         give_verdict();
      end
   end
   initial begin
      repeat (8) @(posedge clk);
      reset <= 0;
      foreach (ROWS[i]) begin
         if (ROWS[i].wr) begin
            wr(ROWS[i].idx, ROWS[i].wd);
         end
         rd(ROWS[i].idx);
         check(rdv, {16'h0, ROWS[i].ex}, "param");
      end
      wr(`DML_IDX_HOLD_TQ, 16'h44);
      rd(8'h01);
      check(erv, 1'b1, "unmapped error");
      wr(`DML_IDX_STATUS, 16'h1);
      check(erv, 1'b1, "status write error");
      @(posedge clk);
      jog_press <= 1;
      @(posedge clk);
      jog_press <= 0;
      @(posedge clk);
      check(jog_step_valid, 1'b1, "jog valid");
      check(jog_steps, 16'h64, "jog steps");
      run_req <= 1;
      repeat (5) @(posedge clk);
      check(motion.torque_limit, 16'h11, "start torque");
      wait_for(0, 16'h14);
      check(wcnt >= 180 && wcnt <= 230, 1'b1, "accel time");
      repeat (3) @(posedge clk);
      check(motion.torque_limit, 16'h22, "run torque");
      check(motion.abort_speed, 16'h12, "abort speed");
      check(motion.moving, 1'b1, "moving");
      rd(`DML_IDX_STATE);
      check(rdv, 32'h2, "state run");
      target_pos <= 5;
      repeat (4) @(posedge clk);
      check(motion.drag_error, 1'b1, "drag flag");
      check(motion.speed, 16'h0f, "drag corrected");
      target_pos <= 4;
      repeat (4) @(posedge clk);
      check(motion.drag_error, 1'b0, "drag at threshold");
      target_pos <= 0;
      actual_pos <= 1;
      wr(`DML_IDX_CORR_LIM, 16'h2);
      rd(`DML_IDX_CORR_LIM);
      check(rdv, 32'ha, "moving write kept");
      jog_press <= 1;
      @(posedge clk);
      jog_press <= 0;
      run_req <= 0;
      @(posedge clk);
      check(jog_step_valid, 1'b0, "jog while moving");
      wait_for(1, 16'h33);
      check(wcnt >= 80 && wcnt <= 130, 1'b1, "decel time");
      wait_for(1, 16'h44);
      check(wcnt >= 25 && wcnt <= 40, 1'b1, "end hold time");
      #1 check(motion.readjust_active, 1'b1, "readjust idle");
      rd(`DML_IDX_STATUS);
      check(rdv, 32'hf, "status");
      check(irq, 1'b0, "irq masked");
      wr(`DML_IDX_ENABLE, 16'h8);
      #1 check(irq, 1'b1, "irq enabled");
      wr(`DML_IDX_CLEAR, 16'h8);
      #1 check(irq, 1'b0, "irq cleared");
      manual_req <= 1;
      repeat (5) @(posedge clk);
      motor_torque <= 16'hffff;
      repeat (3) @(posedge clk);
      s0 = motion.speed;
      check(motion.current_limiting, 1'b1, "current limiting");
      repeat (40) @(posedge clk);
      check(motion.speed, s0, "speed at torque cap");
      motor_torque <= 0;
      wait_for(0, 16'h0a);
      repeat (30) @(posedge clk);
      check(motion.speed, 16'h0a, "manual ceiling");
      manual_req <= 0;
      wait_for(1, 16'h44);
      check(wcnt < 3000, 1'b1, "manual stop");
      manual_req <= 1;
      repeat (60) @(posedge clk);
      reset <= 1;
      manual_req <= 0;
      repeat (2) @(posedge clk);
      check(motion.speed, 16'h0, "speed in reset");
      reset <= 0;
      rd(`DML_IDX_CORR_LIM);
      check(rdv, 32'h4, "limit after reset");
      give_verdict();
   end
endmodule : drive_motion_limits_tb
